/* hdl/flash_gate_map.vh */
`ifndef FLASH_GATE_MAP_VH
`define FLASH_GATE_MAP_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS_1 8'h05
`define OP_READ_STATUS_2 8'h35
`define OP_WRITE_STATUS_1 8'h01
`define OP_WRITE_STATUS_2 8'h31
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE_32 8'h52
`define OP_BLOCK_ERASE_64 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SECURITY_ERASE 8'h44
`define OP_SECURITY_PROGRAM 8'h42

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define SR1_BUSY_BIT 0
`define SR1_LATCH_BIT 1
`define SR1_LVL0_BIT 2
`define SR1_LVL1_BIT 3
`define SR1_LVL2_BIT 4
`define SR1_BOTTOM_BIT 5
`define SR1_GRAN_BIT 6
`define SR2_COMPL_BIT 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_GRAN 1'b0
`define RST_BOTTOM 1'b0
`define RST_LEVEL 3'h0
`define RST_COMPL 1'b0

// ----------------------------------------------------------------
// Array geometry, 18-bit byte address
// ----------------------------------------------------------------
`define ARRAY_TOP 18'h3ffff
`define SIZE_4K 19'h01000
`define SIZE_8K 19'h02000
`define SIZE_16K 19'h04000
`define SIZE_32K 19'h08000
`define SIZE_64K 19'h10000
`define SIZE_128K 19'h20000
`define SIZE_ALL 19'h40000

// ----------------------------------------------------------------
// Byte counts needed before an instruction may run
// ----------------------------------------------------------------
`define BYTES_SIMPLE 9'h001
`define BYTES_STATUS 9'h002
`define BYTES_ERASE 9'h004
`define BYTES_PROGRAM 9'h005

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_MHZ 40
`define STATUS_WRITE_US 10
`define STATUS_WRITE_CYCLES (`STATUS_WRITE_US * `CLOCK_MHZ)

`endif

/* hdl/pin_sync.v */
`timescale 1ns/100ps
`include "flash_gate_map.vh"

module pin_sync #(
  parameter RESET_LEVEL = 1'b0
) (
  clock,
  nrst,
  pin,
  level_q
);
  input wire clock;
  input wire nrst;
  input wire pin;
  output reg level_q;

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ----------------------------------------------------------------
  // Three stages, level follows once stages two and three agree
  // ----------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule

/* hdl/protect_decode.v */
`timescale 1ns/100ps
`include "flash_gate_map.vh"

module protect_decode (
  sector_granularity,
  protect_from_bottom,
  protect_level_2,
  protect_level_1,
  protect_level_0,
  protect_complement,
  prot_none,
  prot_lo,
  prot_hi
);
  input wire sector_granularity;
  input wire protect_from_bottom;
  input wire protect_level_2;
  input wire protect_level_1;
  input wire protect_level_0;
  input wire protect_complement;
  output reg prot_none;
  output reg [17:0] prot_lo;
  output reg [17:0] prot_hi;

  reg [18:0] size;
  reg [17:0] size_m1;
  reg [17:0] top_lo;
  wire [2:0] level;

  assign level = {protect_level_2, protect_level_1, protect_level_0};

  always @* begin
    size = 19'h00000;
    // ----------------------------------------------------------------
    // Region size from granularity and level
    // ----------------------------------------------------------------
    if (!sector_granularity) begin
      // Block sizes, top level bit ignored
      case (level[1:0])
        2'b01: size = `SIZE_64K;
        2'b10: size = `SIZE_128K;
        2'b11: size = `SIZE_ALL;
        default: size = 19'h00000;
      endcase
    end else begin
      case (level)
        3'b001: size = `SIZE_4K;
        3'b010: size = `SIZE_8K;
        3'b011: size = `SIZE_16K;
        3'b100: size = `SIZE_32K;
        3'b101: size = `SIZE_32K;
        3'b110: size = `SIZE_32K;
        3'b111: size = `SIZE_ALL;
        default: size = 19'h00000;
      endcase
    end
    size_m1 = size[17:0] - 18'h00001;
    top_lo = 18'h00000 - size[17:0];
    prot_none = 1'b0;
    prot_lo = 18'h00000;
    prot_hi = `ARRAY_TOP;
    if (size == 19'h00000) begin
      prot_none = ~protect_complement;
    end else if (size == `SIZE_ALL) begin
      prot_none = protect_complement;
    end else if (!protect_complement) begin
      if (protect_from_bottom) begin
        prot_hi = size_m1;
      end else begin
        prot_lo = top_lo;
      end
    end else begin
      if (protect_from_bottom) begin
        prot_lo = size[17:0];
      end else begin
        prot_hi = top_lo - 18'h00001;
      end
    end
  end
endmodule

/* hdl/serial_flash_protect_and_command_gate.v */
// Functional notes
// - Zeros written to reserved status positions change nothing.
// - Block mode protects none, 64KB, half or all, from top or bottom.
// - Complement protects exactly what the plain setting leaves open.
// - Erase or program touching a protected address is dropped.
// - Chip select falling starts decoding a new instruction.
// - The first eight bits after select falls are the opcode.
// - Input bits are taken on clock rising edges, MSB first.
// - Address, data or dummy bytes follow the opcode in sequence.
// - Chip select rising ends the instruction.
// - Reads may end after any clocked bit without error.
// - Write, program and erase end on a byte boundary or are dropped.
// - While busy, only status reads are served.
// - Busy bit is 1 during an operation and clears when it ends.
// - Write enable latch set by write enable, cleared by writes.
// - Direction 0 is top, 1 bottom; granularity 1 is 4KB sectors.
`timescale 1ns/100ps
`include "flash_gate_map.vh"

module serial_flash_protect_and_command_gate #(
  parameter STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLES
) (
  clock,
  nrst,
  chip_select_n,
  serial_clock,
  serial_input,
  serial_output,
  serial_output_en,
  array_done,
  op_start,
  op_code,
  op_addr,
  page_data,
  page_data_valid,
  busy,
  write_enable_latch,
  sector_granularity,
  protect_from_bottom,
  protect_level_2,
  protect_level_1,
  protect_level_0,
  protect_complement
);
  input wire clock;
  input wire nrst;
  input wire chip_select_n;
  input wire serial_clock;
  input wire serial_input;
  output reg serial_output;
  output reg serial_output_en;
  input wire array_done;
  output reg op_start;
  output reg [7:0] op_code;
  output reg [17:0] op_addr;
  output reg [7:0] page_data;
  output reg page_data_valid;
  output wire busy;
  output wire write_enable_latch;
  output wire sector_granularity;
  output wire protect_from_bottom;
  output wire protect_level_2;
  output wire protect_level_1;
  output wire protect_level_0;
  output wire protect_complement;

  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_IGNORE = 2'h2;

  // ----------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------
  function is_status_read;
    input [7:0] op;
    begin
      is_status_read = (op == `OP_READ_STATUS_1) ||
                       (op == `OP_READ_STATUS_2);
    end
  endfunction

  function [8:0] bytes_needed;
    input [7:0] op;
    begin
      case (op)
        `OP_WRITE_ENABLE, `OP_WRITE_DISABLE,
        `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: bytes_needed = `BYTES_SIMPLE;
        `OP_WRITE_STATUS_1, `OP_WRITE_STATUS_2: bytes_needed = `BYTES_STATUS;
        `OP_SECTOR_ERASE, `OP_BLOCK_ERASE_32, `OP_BLOCK_ERASE_64,
        `OP_SECURITY_ERASE: bytes_needed = `BYTES_ERASE;
        `OP_PAGE_PROGRAM,
        `OP_SECURITY_PROGRAM: bytes_needed = `BYTES_PROGRAM;
        default: bytes_needed = 9'h000;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin sampling and edges
  // ----------------------------------------------------------------
  wire cs_n_s;
  wire sclk_s;
  wire din_s;
  reg cs_n_prev_q;
  reg sclk_prev_q;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;

  pin_sync #(.RESET_LEVEL(1'b1)) u_cs (
    .clock(clock),
    .nrst(nrst),
    .pin(chip_select_n),
    .level_q(cs_n_s)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
    .clock(clock),
    .nrst(nrst),
    .pin(serial_clock),
    .level_q(sclk_s)
  );
  pin_sync #(.RESET_LEVEL(1'b0)) u_din (
    .clock(clock),
    .nrst(nrst),
    .pin(serial_input),
    .level_q(din_s)
  );

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_n_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_n_prev_q <= cs_n_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_fall = cs_n_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_n_prev_q & cs_n_s;
  assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_q;

  // ----------------------------------------------------------------
  // Protection settings and decode
  // ----------------------------------------------------------------
  reg gran_q;
  reg bottom_q;
  reg [2:0] bp_q;
  reg compl_q;
  reg wren_q;
  reg busy_q;
  reg timer_run_q;
  reg [15:0] timer_q;
  wire prot_none;
  wire [17:0] prot_lo;
  wire [17:0] prot_hi;

  assign busy = busy_q;
  assign write_enable_latch = wren_q;
  assign sector_granularity = gran_q;
  assign protect_from_bottom = bottom_q;
  assign protect_level_2 = bp_q[2];
  assign protect_level_1 = bp_q[1];
  assign protect_level_0 = bp_q[0];
  assign protect_complement = compl_q;

  protect_decode u_decode (
    .sector_granularity(gran_q),
    .protect_from_bottom(bottom_q),
    .protect_level_2(bp_q[2]),
    .protect_level_1(bp_q[1]),
    .protect_level_0(bp_q[0]),
    .protect_complement(compl_q),
    .prot_none(prot_none),
    .prot_lo(prot_lo),
    .prot_hi(prot_hi)
  );

  // ----------------------------------------------------------------
  // Framing state
  // ----------------------------------------------------------------
  reg [1:0] state_q;
  reg [6:0] shift_q;
  reg [2:0] bit_idx_q;
  reg [8:0] byte_cnt_q;
  reg [7:0] opcode_q;
  reg [23:0] addr_q;
  reg [7:0] sr_data_q;
  wire [7:0] byte_in;
  wire [7:0] sr1;
  wire [7:0] sr2;
  wire [7:0] status_byte;

  assign byte_in = {shift_q, din_s};
  assign sr1 = {1'b0, gran_q, bottom_q, bp_q, wren_q, busy_q};
  assign sr2 = {1'b0, compl_q, 6'h00};
  assign status_byte = (opcode_q == `OP_READ_STATUS_2) ? sr2 : sr1;

  // Target range of the framed instruction
  reg [17:0] tgt_lo;
  reg [17:0] tgt_hi;
  reg checks_range;
  wire hits_protected;

  always @* begin
    tgt_lo = addr_q[17:0];
    tgt_hi = addr_q[17:0];
    checks_range = 1'b1;
    case (opcode_q)
      `OP_PAGE_PROGRAM: begin
        tgt_lo = {addr_q[17:8], 8'h00};
        tgt_hi = {addr_q[17:8], 8'hff};
      end
      `OP_SECTOR_ERASE: begin
        tgt_lo = {addr_q[17:12], 12'h000};
        tgt_hi = {addr_q[17:12], 12'hfff};
      end
      `OP_BLOCK_ERASE_32: begin
        tgt_lo = {addr_q[17:15], 15'h0000};
        tgt_hi = {addr_q[17:15], 15'h7fff};
      end
      `OP_BLOCK_ERASE_64: begin
        tgt_lo = {addr_q[17:16], 16'h0000};
        tgt_hi = {addr_q[17:16], 16'hffff};
      end
      `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
        tgt_lo = 18'h00000;
        tgt_hi = `ARRAY_TOP;
      end
      default: checks_range = 1'b0;
    endcase
  end

  // Any overlap with the protected range
  assign hits_protected = checks_range & ~prot_none &
                          (tgt_lo <= prot_hi) & (tgt_hi >= prot_lo);

  wire end_ok;
  wire op_runs;
  // Whole bytes, enough of them, not busy
  assign end_ok = cs_rise && (state_q == ST_SHIFT) &&
                  (bit_idx_q == 3'h0) && !busy_q &&
                  (bytes_needed(opcode_q) != 9'h000) &&
                  (byte_cnt_q >= bytes_needed(opcode_q));
  assign op_runs = end_ok && wren_q && !hits_protected;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      shift_q <= 7'h00;
      bit_idx_q <= 3'h0;
      byte_cnt_q <= 9'h000;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      sr_data_q <= 8'h00;
      page_data <= 8'h00;
      page_data_valid <= 1'b0;
    end else begin
      page_data_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q <= ST_SHIFT;
            bit_idx_q <= 3'h0;
            byte_cnt_q <= 9'h000;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
          end
        end
        ST_SHIFT: begin
          if (cs_rise) begin
            state_q <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_q <= byte_in[6:0];
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == 3'h7) begin
              if (byte_cnt_q != 9'h1ff) begin
                byte_cnt_q <= byte_cnt_q + 9'h001;
              end
              if (byte_cnt_q == 9'h000) begin
                opcode_q <= byte_in;
                if (busy_q && !is_status_read(byte_in)) begin
                  state_q <= ST_IGNORE;
                end
              end else if (byte_cnt_q <= 9'h003) begin
                // Address, data, dummy bytes in turn
                addr_q <= {addr_q[15:0], byte_in};
                if (byte_cnt_q == 9'h001) begin
                  sr_data_q <= byte_in;
                end
              end else if ((opcode_q == `OP_PAGE_PROGRAM) ||
                           (opcode_q == `OP_SECURITY_PROGRAM)) begin
                page_data <= byte_in;
                page_data_valid <= 1'b1;
              end
            end
          end
        end
        ST_IGNORE: begin
          if (cs_rise) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status read output, driven on falling clock
  // ----------------------------------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      serial_output <= 1'b0;
      serial_output_en <= 1'b0;
    end else begin
      serial_output_en <= (state_q == ST_SHIFT) && !cs_rise &&
                          (byte_cnt_q != 9'h000) &&
                          is_status_read(opcode_q);
      if (sclk_fall && (state_q == ST_SHIFT)) begin
        serial_output <= status_byte[~bit_idx_q];
      end
    end
  end

  // ----------------------------------------------------------------
  // Execution: settings, latch, busy
  // ----------------------------------------------------------------
  wire is_status_write;
  assign is_status_write = (opcode_q == `OP_WRITE_STATUS_1) ||
                           (opcode_q == `OP_WRITE_STATUS_2);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gran_q <= `RST_GRAN;
      bottom_q <= `RST_BOTTOM;
      bp_q <= `RST_LEVEL;
      compl_q <= `RST_COMPL;
      wren_q <= 1'b0;
      busy_q <= 1'b0;
      timer_run_q <= 1'b0;
      timer_q <= 16'h0000;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 18'h00000;
    end else begin
      op_start <= 1'b0;
      if (end_ok && (opcode_q == `OP_WRITE_ENABLE)) begin
        wren_q <= 1'b1;
      end else if (end_ok && (opcode_q == `OP_WRITE_DISABLE)) begin
        wren_q <= 1'b0;
      end else if (op_runs) begin
        wren_q <= 1'b0;
        busy_q <= 1'b1;
        if (is_status_write) begin
          if (opcode_q == `OP_WRITE_STATUS_1) begin
            gran_q <= sr_data_q[`SR1_GRAN_BIT];
            bottom_q <= sr_data_q[`SR1_BOTTOM_BIT];
            bp_q <= sr_data_q[`SR1_LVL2_BIT:`SR1_LVL0_BIT];
          end else begin
            compl_q <= sr_data_q[`SR2_COMPL_BIT];
          end
          timer_run_q <= 1'b1;
          timer_q <= STATUS_WRITE_CYCLES[15:0];
        end else begin
          op_start <= 1'b1;
          op_code <= opcode_q;
          op_addr <= addr_q[17:0];
        end
      end
      if (timer_run_q) begin
        if (timer_q <= 16'h0001) begin
          timer_run_q <= 1'b0;
          busy_q <= 1'b0;
        end else begin
          timer_q <= timer_q - 16'h0001;
        end
      end else if (busy_q && !op_runs && array_done) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule

/* tb/prot_ref.svh */
`ifndef PROT_REF_SVH
`define PROT_REF_SVH

// ------------------------------------------------------------
// Protected span reference
// ------------------------------------------------------------
// Bytes touched by an array opcode, zero if none
function automatic logic [18:0] tsize(input logic [7:0] c);
  case (c)
    8'h20: tsize = 19'h01000;
    8'h52: tsize = 19'h08000;
    8'hd8: tsize = 19'h10000;
    8'h02: tsize = 19'h00100;
    8'hc7, 8'h60: tsize = 19'h40000;
    default: tsize = 19'h0;
  endcase
endfunction

// protected span test
// s is complement, granularity, bottom, level 2 to 0
function automatic logic hit(input logic [5:0] s, input logic [17:0] a,
    input logic [18:0] n);
  logic [18:0] z, b, e;
  logic inr, ovl;
  if (s[4])
    z = s[2:0] == 3'h7 ? 19'h40000 : s[2] ? 19'h08000 :
        s[2:0] == 3'h0 ? 19'h0 : 19'h00800 << s[1:0];
  else
    z = s[1:0] == 2'h3 ? 19'h40000 : {1'b0, s[1:0], 16'h0};
  b = {1'b0, a} & ~(n - 19'h1);
  e = b + n - 19'h1;
  inr = z != 19'h0 && (s[3] ? e < z : b >= 19'h40000 - z);
  ovl = z != 19'h0 && (s[3] ? b < z : e >= 19'h40000 - z);
  hit = n != 19'h0 && (s[5] ? !inr : ovl);
endfunction

`endif

/* tb/flash_gate_chk.sv */
`timescale 1ns/100ps
`include "prot_ref.svh"

module flash_gate_chk #(
  parameter STATUS_WRITE_CYCLES = 400
) (
  input wire clock,
  input wire nrst,
  input wire chip_select_n,
  input wire serial_output_en,
  input wire op_start,
  input wire [7:0] op_code,
  input wire [17:0] op_addr,
  input wire busy,
  input wire write_enable_latch,
  input wire sector_granularity,
  input wire protect_from_bottom,
  input wire protect_level_2,
  input wire protect_level_1,
  input wire protect_level_0,
  input wire protect_complement
);
  localparam int SW_MAX = STATUS_WRITE_CYCLES + 4;
  wire [5:0] s = {protect_complement, sector_granularity,
    protect_from_bottom, protect_level_2, protect_level_1, protect_level_0};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  start_after_cs_a: assert property (
    op_start |-> chip_select_n && $past(chip_select_n, 4))
    else $error("array op started inside a frame");
  op_pulse_a: assert property (op_start |=> !op_start)
    else $error("op start longer than one cycle");
  op_sets_busy_a: assert property (
    op_start |-> busy && !write_enable_latch)
    else $error("op start without busy or with latch set");
  no_start_busy_a: assert property (op_start |-> !$past(busy))
    else $error("op started while busy");
  busy_locks_wel_a: assert property (
    busy && $past(busy) |-> !$rose(write_enable_latch))
    else $error("latch set while busy");
  busy_holds_set_a: assert property ($past(busy) |-> $stable(s))
    else $error("settings changed while busy");
  set_needs_busy_a: assert property (!$stable(s) |-> busy)
    else $error("settings changed without busy");
  sw_ends_a: assert property (!$stable(s) |-> ##[1:SW_MAX] !busy)
    else $error("status write busy too long");
  prot_hit_a: assert property (
    op_start |-> !hit(s, op_addr, tsize(op_code)))
    else $error("op started on protected range");
  oe_idle_a: assert property (
    chip_select_n [*8] |-> !serial_output_en)
    else $error("output driven while deselected");

  cover property (op_start);
  cover property ($rose(busy) && !op_start);
  cover property ($rose(serial_output_en));
endmodule

bind serial_flash_protect_and_command_gate flash_gate_chk #(
  .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)
) u_chk (
  .clock(clock),
  .nrst(nrst),
  .chip_select_n(chip_select_n),
  .serial_output_en(serial_output_en),
  .op_start(op_start),
  .op_code(op_code),
  .op_addr(op_addr),
  .busy(busy),
  .write_enable_latch(write_enable_latch),
  .sector_granularity(sector_granularity),
  .protect_from_bottom(protect_from_bottom),
  .protect_level_2(protect_level_2),
  .protect_level_1(protect_level_1),
  .protect_level_0(protect_level_0),
  .protect_complement(protect_complement)
);

/* tb/spi_host_model.sv */
`timescale 1ns/100ps

module spi_host_model (
  input wire clock,
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_input,
  input wire serial_output
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_input = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Send bits of d from the top, then shift in nread bits
  task automatic xfer(input logic [39:0] d, input int nsend,
      input int nread, output logic [7:0] rd);
    int i;
    rd = 8'h0;
    chip_select_n = 1'b0;
    tick(4);
    for (i = 0; i < nsend + nread; i++) begin
      serial_clock = 1'b0;
      serial_input = i < nsend ? d[39 - i] : ~serial_input;
      tick(4);
      serial_clock = 1'b1;
      tick(4);
      if (i >= nsend)
        rd = {rd[6:0], serial_output};
    end
    serial_clock = 1'b0;
    tick(4);
    chip_select_n = 1'b1;
    serial_input = ~serial_input;
    tick(8);
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
`include "prot_ref.svh"
`define CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("wrong value at %0t: got %h expected %h", \
        $time, got, exp); \
    end \
  end

module tb_top;
  localparam int SWC = 8;
  logic clock, nrst, array_done, h;
  logic [31:0] rng;
  logic [7:0] rd, c;
  logic [5:0] s;
  logic [17:0] a;
  logic [25:0] e;
  logic [25:0] expq[$];
  int failures = 0, compares = 0, pulses = 0, i;
  wire chip_select_n, serial_clock, serial_input, serial_output;
  wire serial_output_en, op_start, page_data_valid, busy;
  wire write_enable_latch, sector_granularity, protect_from_bottom;
  wire protect_level_2, protect_level_1, protect_level_0;
  wire protect_complement;
  wire [7:0] op_code, page_data;
  wire [17:0] op_addr;
  wire [5:0] sets = {protect_complement, sector_granularity,
    protect_from_bottom, protect_level_2, protect_level_1, protect_level_0};

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  serial_flash_protect_and_command_gate #(
    .STATUS_WRITE_CYCLES(SWC)
  ) u_dut (
    .clock(clock),
    .nrst(nrst),
    .chip_select_n(chip_select_n),
    .serial_clock(serial_clock),
    .serial_input(serial_input),
    .serial_output(serial_output),
    .serial_output_en(serial_output_en),
    .array_done(array_done),
    .op_start(op_start),
    .op_code(op_code),
    .op_addr(op_addr),
    .page_data(page_data),
    .page_data_valid(page_data_valid),
    .busy(busy),
    .write_enable_latch(write_enable_latch),
    .sector_granularity(sector_granularity),
    .protect_from_bottom(protect_from_bottom),
    .protect_level_2(protect_level_2),
    .protect_level_1(protect_level_1),
    .protect_level_0(protect_level_0),
    .protect_complement(protect_complement)
  );

  spi_host_model u_host (
    .clock(clock),
    .chip_select_n(chip_select_n),
    .serial_clock(serial_clock),
    .serial_input(serial_input),
    .serial_output(serial_output)
  );

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmd(input logic [39:0] d, input int n, input int r);
    u_host.xfer(d, n, r, rd);
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 2000 && busy !== 1'b0; k++)
      step(1);
    `CHECK(busy, 1'b0)
  endtask

  task automatic wren;
    cmd({8'h06, 32'h0}, 8, 0);
    `CHECK(write_enable_latch, 1'b1)
  endtask

  task automatic wsr(input logic [15:0] d);
    wren();
    cmd({d, 24'h0}, 16, 0);
    `CHECK(busy, 1'b1)
    `CHECK(write_enable_latch, 1'b0)
    wait_idle();
  endtask

  task automatic finish_op;
    array_done = 1'b1;
    step(1);
    array_done = 1'b0;
    wait_idle();
  endtask

  // ------------------------------------------------------------
  // Array op watcher
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (page_data_valid === 1'b1)
      pulses++;
    if (op_start === 1'b1) begin
      e = expq.size() != 0 ? expq.pop_front() : 26'h0;
      `CHECK({op_code, op_addr}, e)
    end
  end

  initial begin
    #(25 * 90000);
    failures++;
    test_done();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    array_done = 1'b0;
    rng = 32'h0000050e;
    repeat (12) @(posedge clock);
    #1;
    nrst = 1'b1;
    step(6);
    `CHECK({busy, write_enable_latch, sets}, 8'h0)
    cmd({8'h05, 32'h0}, 8, 3);
    wren();
    cmd({8'h04, 32'h0}, 8, 0);
    `CHECK(write_enable_latch, 1'b0)
    for (i = 0; i < 64; i++) begin
      s = i[5:0];
      wsr({8'h01, 1'b0, s[4:0], 2'b00});
      wsr({8'h31, 1'b0, s[5], 6'h0});
      `CHECK(sets, s)
      cmd({8'h05, 32'h0}, 8, 8);
      `CHECK(rd & 8'h7f, {1'b0, s[4:0], 2'b00})
      rng = xs(rng);
      a = rng[17:0];
      c = i % 3 == 0 ? 8'h20 : i % 3 == 1 ? 8'h52 : 8'hd8;
      h = hit(s, a, tsize(c));
      wren();
      if (!h)
        expq.push_back({c, a});
      cmd({c, 6'h0, a, 8'h0}, 32, 0);
      if (h) begin
        `CHECK({busy, write_enable_latch}, 2'b01)
      end else begin
        `CHECK(busy, 1'b1)
        if (i < 6) begin
          cmd({8'h06, 32'h0}, 8, 0);
          `CHECK(write_enable_latch, 1'b0)
          cmd({8'h05, 32'h0}, 8, 8);
          `CHECK(rd & 8'h03, 8'h01)
        end
        finish_op();
      end
    end
    wren();
    cmd({8'h20, 32'h0}, 31, 0);
    `CHECK({busy, write_enable_latch}, 2'b01)
    // Second status byte, page program, chip erase
    cmd({8'h35, 32'h0}, 8, 8);
    `CHECK(rd & 8'h7f, 8'h40)
    rng = xs(rng);
    expq.push_back({8'h02, rng[17:0]});
    cmd({8'h02, 6'h0, rng[17:0], rng[31:24]}, 40, 0);
    `CHECK({page_data, pulses}, {rng[31:24], 32'd1})
    finish_op();
    wren();
    expq.push_back({8'hc7, 18'h0});
    cmd({8'hc7, 32'h0}, 8, 0);
    `CHECK(busy, 1'b1)
    finish_op();
    // Complement cleared: whole array protected
    wsr({8'h31, 8'h00});
    wren();
    cmd({8'h60, 32'h0}, 8, 0);
    `CHECK({busy, write_enable_latch}, 2'b01)
    step(20);
    `CHECK(expq.size(), 0)
    test_done();
  end
endmodule
